// >>> hw/gauge_readout.sv
// What this block does
// - Time-to-full at 0x05 recomputed within 5 ms of a new rate write.
// - All three rate predictions refreshed from the current rate every second.
// - Time-to-full is minutes 0..65534; 65535 when rate is zero or negative.
// - Time-to-empty at 0x06 recomputed within 5 ms of a new rate write.
// - Time-to-empty is minutes 0..65534; 65535 when rate is zero or positive.
// - Code 0x07 returns one-bit flag: can battery carry extra load ten seconds.
// - Can-supply flag reads 1 whenever rate is zero or positive.
// - Can-supply flag recomputed within 5 ms of a new rate write.
// - Code 0x08 returns cell temperature, unsigned, in tenths of a kelvin.
// - Code 0x09 returns pack voltage in millivolts, 0 to 20000.
// - Code 0x0a returns signed instantaneous current in mA, positive when charging.
// - Code 0x0b returns one-minute rolling average; instant value during first minute.
// - Full reset sets error margin at 0x0c to 100 percent.
// - Learning sets margin 2; clamped learning sets 8 unless already below 8.
// - Margin gains 1 percent per four cycle-count increments without learning.
// - Voltage-based coulomb counter correction sets margin to 25 percent.
// - Code 0x0d returns remaining as percent 0..100 of learned full capacity.
// - Code 0x0e returns remaining as percent of design capacity, may exceed 100.
// - Code 0x0f returns remaining in mAh, or 10 mWh when unit select set.
// - Host reads each result by read-word only; device answers a 16-bit word.
// - Mode word bit 15 selects units: clear mA/mAh, set 10 mW/10 mWh.
`timescale 1ns/1ps
`include "gauge_readout_defines.svh"

module gauge_readout
    import gauge_readout_pkg::*;
#(
    parameter int unsigned REFRESH_CYCLES = `REFRESH_MS * (`CLK_HZ / 1000)
) (
    input  wire logic               clk_sys,
    input  wire logic               nrst,
    input  wire logic               readReq,
    input  wire logic [7:0]         readCode,
    output logic      [15:0]        readWord,
    output logic                    readValid,
    output logic                    readMiss,
    input  wire logic               rateWrite,
    input  wire logic signed [15:0] host_rate_value,
    input  wire logic [15:0]        mode_word,
    input  wire logic [15:0]        cellTempDk,
    input  wire logic [15:0]        packVoltMv,
    input  wire logic signed [15:0] instCurrentMa,
    input  wire logic [15:0]        remainMah,
    input  wire logic [15:0]        remainCwh,
    input  wire logic [15:0]        learnedFullMah,
    input  wire logic [15:0]        learnedFullCwh,
    input  wire logic [15:0]        nominal_full_amount,
    input  wire logic               learnDone,
    input  wire logic               learnClamped,
    input  wire logic               cycleTallyIncr,
    input  wire logic               voltCorrection,
    output logic                    calcBusy
);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] sat16(input logic [31:0] v, input logic [15:0] lim);
        sat16 = (v > {16'h0000, lim}) ? lim : v[15:0];
    endfunction : sat16

    function automatic logic [15:0] mag16(input logic signed [15:0] v);
        mag16 = v[15] ? 16'(-v) : 16'(v);
    endfunction : mag16

    ////////////////////////////////////////////////////////////////////////////
    logic signed [15:0] rate_reg;
    logic [24:0]        secCount_reg;
    logic               secTick;
    logic               pend_reg;
    calc_state_e        state_reg;
    calc_job_e          job_reg;
    logic [31:0]        num_reg;
    logic [31:0]        den_reg;
    logic [31:0]        quo_reg;
    logic [32:0]        rem_reg;
    logic [5:0]         bitCnt_reg;
    logic               skip_reg;
    logic [15:0]        ttf_reg;
    logic [15:0]        tte_reg;
    logic               canSupply_reg;
    logic [15:0]        relPct_reg;
    logic [15:0]        absPct_reg;
    logic [15:0]        avgCur_reg;
    logic [15:0]        margin_reg;
    logic [1:0]         cycleRun_reg;
    logic signed [15:0] avgMem [0:`AVG_WINDOW_S-1];
    logic [5:0]         avgPtr_reg;
    logic               avgFull_reg;
    logic signed [23:0] avgSum_reg;
    logic               unitSel;
    logic [15:0]        remSel;
    logic [15:0]        fullSel;
    logic [15:0]        rateMag;
    logic [32:0]        remTry;

    assign unitSel  = mode_word[`MODE_UNIT_BIT];
    assign remSel   = unitSel ? remainCwh : remainMah;
    assign fullSel  = unitSel ? learnedFullCwh : learnedFullMah;
    assign rateMag  = mag16(rate_reg);
    assign calcBusy = (state_reg != CALC_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Rate value, zero after reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rate_reg <= 16'sh0000;
        end else if (rateWrite) begin
            rate_reg <= host_rate_value;
        end
    end

    // One-second refresh divider
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            secCount_reg <= 25'h0000000;
        end else if (secTick) begin
            secCount_reg <= 25'h0000000;
        end else begin
            secCount_reg <= secCount_reg + 25'h0000001;
        end
    end
    assign secTick = (secCount_reg == 25'(REFRESH_CYCLES - 1));

    // Pending recompute; a trigger arriving at launch is kept
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= (pend_reg && state_reg != CALC_IDLE) || rateWrite || secTick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared serial divider; five jobs take under 200 cycles, far inside 5 ms
    assign remTry = {rem_reg[31:0], num_reg[31]} - {1'b0, den_reg};

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg  <= CALC_IDLE;
            job_reg    <= JOB_TTF;
            num_reg    <= 32'h00000000;
            den_reg    <= 32'h00000000;
            quo_reg    <= 32'h00000000;
            rem_reg    <= 33'h000000000;
            bitCnt_reg <= 6'h00;
            skip_reg   <= 1'b0;
        end else begin
            case (state_reg)
                CALC_IDLE: begin
                    if (pend_reg) begin
                        job_reg   <= JOB_TTF;
                        state_reg <= CALC_LOAD;
                    end
                end
                CALC_LOAD: begin
                    rem_reg    <= 33'h000000000;
                    quo_reg    <= 32'h00000000;
                    bitCnt_reg <= 6'h20;
                    state_reg  <= CALC_DIV;
                    skip_reg   <= 1'b0;
                    den_reg    <= {16'h0000, rateMag};
                    num_reg    <= 32'h00000000;
                    case (job_reg)
                        JOB_TTF: begin
                            skip_reg <= (rate_reg <= 16'sh0000);
                            if (fullSel > remSel) begin
                                num_reg <= 32'(fullSel - remSel) * 32'(`MINUTES_PER_HOUR);
                            end
                        end
                        JOB_TTE: begin
                            skip_reg <= (rate_reg >= 16'sh0000);
                            num_reg  <= 32'(remSel) * 32'(`MINUTES_PER_HOUR);
                        end
                        JOB_REL: begin
                            num_reg <= 32'(remainMah) * 32'(`PCT_FULL);
                            den_reg <= {16'h0000, learnedFullMah};
                        end
                        JOB_ABS: begin
                            num_reg <= 32'(remainMah) * 32'(`PCT_FULL);
                            den_reg <= {16'h0000, nominal_full_amount};
                        end
                        JOB_AVG: begin
                            num_reg <= avgSum_reg[23] ? 32'(-avgSum_reg) : 32'(avgSum_reg);
                            den_reg <= 32'(`AVG_WINDOW_S);
                        end
                        default: begin
                            skip_reg <= 1'b1;
                        end
                    endcase
                end
                CALC_DIV: begin
                    if (bitCnt_reg == 6'h00) begin
                        state_reg <= CALC_STORE;
                    end else begin
                        bitCnt_reg <= bitCnt_reg - 6'h01;
                        num_reg    <= {num_reg[30:0], 1'b0};
                        if (!remTry[32]) begin
                            rem_reg <= remTry;
                            quo_reg <= {quo_reg[30:0], 1'b1};
                        end else begin
                            rem_reg <= {rem_reg[31:0], num_reg[31]};
                            quo_reg <= {quo_reg[30:0], 1'b0};
                        end
                    end
                end
                CALC_STORE: begin
                    if (job_reg == JOB_AVG) begin
                        state_reg <= CALC_IDLE;
                    end else begin
                        job_reg   <= calc_job_e'(job_reg + 3'h1);
                        state_reg <= CALC_LOAD;
                    end
                end
                default: begin
                    state_reg <= CALC_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Results; a zero divisor yields all ones and saturates
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ttf_reg    <= `TIME_INVALID;
            tte_reg    <= `TIME_INVALID;
            relPct_reg <= 16'h0000;
            absPct_reg <= 16'h0000;
            avgCur_reg <= 16'h0000;
        end else if (state_reg == CALC_STORE) begin
            case (job_reg)
                JOB_TTF: ttf_reg <= skip_reg ? `TIME_INVALID : sat16(quo_reg, `TIME_MAX);
                JOB_TTE: tte_reg <= skip_reg ? `TIME_INVALID : sat16(quo_reg, `TIME_MAX);
                JOB_REL: relPct_reg <= sat16(quo_reg, `PCT_FULL);
                JOB_ABS: absPct_reg <= sat16(quo_reg, 16'hffff);
                JOB_AVG: begin
                    if (avgSum_reg[23]) begin
                        avgCur_reg <= 16'(-quo_reg);
                    end else begin
                        avgCur_reg <= quo_reg[15:0];
                    end
                end
                default: begin
                    avgCur_reg <= avgCur_reg;
                end
            endcase
        end
    end

    // Extra load check; present averaged drain counts only in current units
    logic [31:0] needLoad;
    logic [31:0] haveCharge;
    logic [15:0] drainNow;
    assign drainNow   = (!unitSel && avgCur_reg[15]) ? mag16(avgCur_reg) : 16'h0000;
    assign needLoad   = (32'(rateMag) + 32'(drainNow)) * 32'(`SUPPLY_SECONDS);
    assign haveCharge = 32'(remSel) * 32'(`SECONDS_PER_HOUR);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            canSupply_reg <= 1'b1;
        end else if (state_reg == CALC_IDLE && pend_reg) begin
            canSupply_reg <= (rate_reg >= 16'sh0000) || (needLoad <= haveCharge);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One-minute window of per-second samples
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            avgPtr_reg  <= 6'h00;
            avgFull_reg <= 1'b0;
            avgSum_reg  <= 24'sh000000;
        end else if (secTick) begin
            avgPtr_reg <= (avgPtr_reg == 6'(`AVG_WINDOW_S - 1)) ? 6'h00 : avgPtr_reg + 6'h01;
            if (avgPtr_reg == 6'(`AVG_WINDOW_S - 1)) begin
                avgFull_reg <= 1'b1;
            end
            if (avgFull_reg) begin
                avgSum_reg <= avgSum_reg + 24'(instCurrentMa) - 24'(avgMem[avgPtr_reg]);
            end else begin
                avgSum_reg <= avgSum_reg + 24'(instCurrentMa);
            end
        end
    end

    // Sample store needs no reset; unread until the window has filled
    always_ff @(posedge clk_sys) begin
        if (secTick) begin
            avgMem[avgPtr_reg] <= instCurrentMa;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error margin; correction beats learning beats cycle aging
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            margin_reg   <= `MARGIN_RESET;
            cycleRun_reg <= 2'h0;
        end else if (voltCorrection) begin
            margin_reg <= `MARGIN_VCORR;
        end else if (learnDone) begin
            cycleRun_reg <= 2'h0;
            if (!learnClamped) begin
                margin_reg <= `MARGIN_LEARNED;
            end else if (margin_reg >= `MARGIN_CLAMPED) begin
                margin_reg <= `MARGIN_CLAMPED;
            end
        end else if (cycleTallyIncr) begin
            cycleRun_reg <= cycleRun_reg + 2'h1;
            if (cycleRun_reg == `CYCLES_PER_STEP && margin_reg < `MARGIN_RESET) begin
                margin_reg <= margin_reg + `MARGIN_STEP;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read-word answers, one cycle after the request
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            readWord  <= 16'h0000;
            readValid <= 1'b0;
            readMiss  <= 1'b0;
        end else begin
            readValid <= readReq;
            readMiss  <= 1'b0;
            if (readReq) begin
                case (readCode)
                    `CMD_TIME_TO_FULL:  readWord <= ttf_reg;
                    `CMD_TIME_TO_EMPTY: readWord <= tte_reg;
                    `CMD_CAN_SUPPLY:    readWord <= {15'h0000, canSupply_reg};
                    `CMD_TEMPERATURE:   readWord <= cellTempDk;
                    `CMD_VOLTAGE:       readWord <= sat16(32'(packVoltMv), `VOLT_MAX_MV);
                    `CMD_CURRENT:       readWord <= instCurrentMa;
                    `CMD_AVG_CURRENT:   readWord <= avgFull_reg ? avgCur_reg : instCurrentMa;
                    `CMD_ERROR_MARGIN:  readWord <= margin_reg;
                    `CMD_PCT_LEARNED:   readWord <= relPct_reg;
                    `CMD_PCT_DESIGN:    readWord <= absPct_reg;
                    `CMD_REMAINING:     readWord <= remSel;
                    default: begin
                        readWord <= 16'h0000;
                        readMiss <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule : gauge_readout

// >>> pkg/gauge_readout_defines.svh
`ifndef GAUGE_READOUT_DEFINES_SVH
`define GAUGE_READOUT_DEFINES_SVH

// Command codes of the read-word results
`define CMD_TIME_TO_FULL    8'h05
`define CMD_TIME_TO_EMPTY   8'h06
`define CMD_CAN_SUPPLY      8'h07
`define CMD_TEMPERATURE     8'h08
`define CMD_VOLTAGE         8'h09
`define CMD_CURRENT         8'h0a
`define CMD_AVG_CURRENT     8'h0b
`define CMD_ERROR_MARGIN    8'h0c
`define CMD_PCT_LEARNED     8'h0d
`define CMD_PCT_DESIGN      8'h0e
`define CMD_REMAINING       8'h0f

// Mode word field
`define MODE_UNIT_BIT       15

// Result codes and limits
`define TIME_INVALID        16'hffff
`define TIME_MAX            16'hfffe
`define PCT_FULL            16'h0064
`define VOLT_MAX_MV         16'h4e20

// Error margin values in percent; CYCLES_PER_STEP is the cycle-count compare value
`define MARGIN_RESET        16'h0064
`define MARGIN_LEARNED      16'h0002
`define MARGIN_CLAMPED      16'h0008
`define MARGIN_VCORR        16'h0019
`define MARGIN_STEP         16'h0001
`define CYCLES_PER_STEP     2'h3

// Timing
`define CLK_HZ              20000000
`define REFRESH_MS          1000
`define RESULT_DEADLINE_MS  5
`define SUPPLY_SECONDS      10
`define SECONDS_PER_HOUR    3600
`define MINUTES_PER_HOUR    60
`define AVG_WINDOW_S        60

`endif

// >>> pkg/gauge_readout_pkg.sv
package gauge_readout_pkg;

    typedef enum logic [3:0] {
        CALC_IDLE  = 4'b0001,
        CALC_LOAD  = 4'b0010,
        CALC_DIV   = 4'b0100,
        CALC_STORE = 4'b1000
    } calc_state_e;

    typedef enum logic [2:0] {
        JOB_TTF = 3'h0,
        JOB_TTE = 3'h1,
        JOB_REL = 3'h2,
        JOB_ABS = 3'h3,
        JOB_AVG = 3'h4
    } calc_job_e;

    typedef logic [15:0] word_t;

endpackage : gauge_readout_pkg

// >>> tb/gauge_readout_monitor.sv
`timescale 1ns/1ps
module gauge_readout_monitor #(
    parameter int unsigned REFRESH_CYCLES = 20000000
) (
    input wire logic               clk_sys,
    input wire logic               nrst,
    input wire logic               readReq,
    input wire logic [7:0]         readCode,
    input wire logic [15:0]        readWord,
    input wire logic               readValid,
    input wire logic               readMiss,
    input wire logic               rateWrite,
    input wire logic signed [15:0] host_rate_value,
    input wire logic [15:0]        mode_word,
    input wire logic [15:0]        cellTempDk,
    input wire logic [15:0]        packVoltMv,
    input wire logic signed [15:0] instCurrentMa,
    input wire logic [15:0]        remainMah,
    input wire logic [15:0]        remainCwh,
    input wire logic               voltCorrection,
    input wire logic               calcBusy
);
    ////////////////////////////////////////////////////////////
    // Results count as settled once 200 cycles passed since the write
    logic [8:0]         settleCnt;
    logic signed [15:0] rateSeen;
    logic [31:0]        idleCnt;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            settleCnt <= 9'h1ff;
            rateSeen  <= 16'sh0000;
        end else if (rateWrite) begin
            settleCnt <= 9'h000;
            rateSeen  <= host_rate_value;
        end else if (settleCnt != 9'h1ff) begin
            settleCnt <= settleCnt + 9'h001;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            idleCnt <= 32'h0;
        end else begin
            idleCnt <= calcBusy ? 32'h0 : idleCnt + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_read_answer: assert property (readReq |=> readValid)
        else $error("read request not answered");
    a_valid_cause: assert property (readValid |-> $past(readReq))
        else $error("answer without request");
    a_miss_zero: assert property (readMiss |-> readValid && readWord == 16'h0000)
        else $error("unmapped answer not zero");
    a_ttf_invalid: assert property (readReq && readCode == 8'h05 && settleCnt >= 9'h0c8 && rateSeen <= 0
        |=> readWord == 16'hffff) else $error("time to full not invalid");
    a_tte_invalid: assert property (readReq && readCode == 8'h06 && settleCnt >= 9'h0c8 && rateSeen >= 0
        |=> readWord == 16'hffff) else $error("time to empty not invalid");
    a_supply_one: assert property (readReq && readCode == 8'h07 && settleCnt >= 9'h0c8 && rateSeen >= 0
        |=> readWord == 16'h0001) else $error("can supply not one");
    a_temp_pass: assert property (readReq && readCode == 8'h08 |=> readWord == $past(cellTempDk))
        else $error("temperature word wrong");
    a_volt_clamp: assert property (readReq && readCode == 8'h09
        |=> readWord == ($past(packVoltMv) > 16'h4e20 ? 16'h4e20 : $past(packVoltMv))) else $error("voltage wrong");
    a_current_pass: assert property (readReq && readCode == 8'h0a |=> readWord == $past(instCurrentMa))
        else $error("current word wrong");
    a_remain_unit: assert property (readReq && readCode == 8'h0f
        |=> readWord == ($past(mode_word[15]) ? $past(remainCwh) : $past(remainMah))) else $error("remaining wrong");
    a_margin_vcorr: assert property (voltCorrection ##1 (readReq && readCode == 8'h0c)
        |=> readWord == 16'h0019) else $error("margin after correction wrong");
    a_busy_start: assert property (rateWrite && !calcBusy |-> ##2 calcBusy)
        else $error("engine not started by write");
    a_busy_bound: assert property ($rose(calcBusy) |-> ##[1:450] !calcBusy)
        else $error("engine run too long");
    a_refresh_period: assert property (idleCnt <= REFRESH_CYCLES + 8)
        else $error("periodic refresh missing");
endmodule : gauge_readout_monitor

bind gauge_readout gauge_readout_monitor #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_monitor (.*);

// >>> tb/gauge_host_model.sv
`timescale 1ns/1ps
module gauge_host_model (
    input  wire logic          clk_sys,
    input  wire logic [15:0]   readWord,
    input  wire logic          readValid,
    input  wire logic          readMiss,
    output logic               readReq,
    output logic [7:0]         readCode,
    output logic               rateWrite,
    output logic signed [15:0] host_rate_value
);
    initial begin
        readReq         = 1'b0;
        readCode        = 8'h00;
        rateWrite       = 1'b0;
        host_rate_value = 16'sh0000;
    end

    // Called at a falling edge; returns at a falling edge
    task automatic read_word(input logic [7:0] code, output logic [15:0] w, output logic miss);
        int i;
        readReq  = 1'b1;
        readCode = code;
        @(negedge clk_sys);
        readReq  = 1'b0;
        readCode = ~code;
        for (i = 0; i < 4 && readValid !== 1'b1; i++) @(negedge clk_sys);
        w    = readValid ? readWord : 16'hxxxx;
        miss = readMiss;
        // Spare cycle, so a next call never re-raises the request in the same step
        @(negedge clk_sys);
    endtask : read_word

    // Rate is inverted after the strobe so a late sample shows up
    task automatic write_rate(input logic signed [15:0] r);
        rateWrite       = 1'b1;
        host_rate_value = r;
        @(negedge clk_sys);
        rateWrite       = 1'b0;
        host_rate_value = ~r;
    endtask : write_rate
endmodule : gauge_host_model

// >>> tb/tb.sv
`timescale 1ns/1ps
`include "gauge_readout_defines.svh"
module tb
    import gauge_readout_pkg::*;
;
    localparam int unsigned RC = 300;
    logic               clk_sys, nrst, readReq, readValid, readMiss, rateWrite, calcBusy, m;
    logic               learnDone, learnClamped, cycleTallyIncr, voltCorrection;
    logic [7:0]         readCode, c;
    word_t              readWord, mode_word, cellTempDk, packVoltMv, remainMah, remainCwh, w;
    word_t              learnedFullMah, learnedFullCwh, nominal_full_amount;
    logic signed [15:0] host_rate_value, instCurrentMa;
    int                 num_errors, num_checks, rateNow;
    logic [31:0]        seed;
    logic [7:0]         predCodes [5] = '{8'h05, 8'h06, 8'h07, 8'h0d, 8'h0e};
    logic [7:0]         codes [5] = '{8'h08, 8'h09, 8'h0a, 8'h0f, 8'h30};
    int                 evs [9] = '{0, 1, 2, 2, 2, 2, 3, 0, 3};
    word_t              margins [9] = '{16'h19, 16'h2, 16'h2, 16'h2, 16'h2, 16'h3, 16'h3, 16'h19, 16'h8};

    gauge_readout #(.REFRESH_CYCLES(RC)) u_dut (.*);
    gauge_host_model u_host (.*);

    ////////////////////////////////////////////////////////////
    function automatic word_t rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction : rnd

    function automatic word_t direct(input logic [7:0] k);
        case (k)
            `CMD_TEMPERATURE: return cellTempDk;
            `CMD_VOLTAGE:     return packVoltMv > `VOLT_MAX_MV ? `VOLT_MAX_MV : packVoltMv;
            `CMD_CURRENT:     return instCurrentMa;
            `CMD_REMAINING:   return mode_word[`MODE_UNIT_BIT] ? remainCwh : remainMah;
            default:          return 16'h0000;
        endcase
    endfunction : direct

    // Integer-only forms; mAh mode with a charging present current
    function automatic word_t pred(input logic [7:0] k);
        int rem;
        rem = int'(remainMah);
        case (k)
            8'h05:   return rateNow <= 0 ? `TIME_INVALID : word_t'((int'(learnedFullMah) - rem) * 60 / rateNow);
            8'h06:   return rateNow >= 0 ? `TIME_INVALID : word_t'(rem * 60 / -rateNow);
            8'h0d:   return word_t'(rem * 100 / int'(learnedFullMah));
            8'h0e:   return word_t'(rem * 100 / int'(nominal_full_amount));
            default: return (rateNow >= 0 || -rateNow * 10 <= rem * 3600) ? 16'h0001 : 16'h0000;
        endcase
    endfunction : pred

    task automatic chk(input string what, input word_t exp, input word_t got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_sim();
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic rd(input logic [7:0] k, input word_t exp);
        u_host.read_word(k, w, m);
        chk($sformatf("code %h", k), exp, w);
        if ($isunknown(w)) end_sim();
    endtask : rd

    task automatic ev(input int k);
        voltCorrection = (k == 0);
        learnDone      = (k == 1 || k == 3);
        learnClamped   = (k == 3);
        cycleTallyIncr = (k == 2);
        @(negedge clk_sys);
        {voltCorrection, learnDone, learnClamped, cycleTallyIncr} = 4'h0;
    endtask : ev

    // Every result is stored within 200 cycles of a write that finds the engine idle
    task automatic settle();
        int i;
        repeat (200) @(negedge clk_sys);
        for (i = 0; i < 400 && calcBusy !== 1'b0; i++) @(negedge clk_sys);
        chk("engine idle", 16'h0000, {15'h0, calcBusy});
        if (calcBusy !== 1'b0) end_sim();
    endtask : settle

    task automatic predict(input int r);
        u_host.write_rate(16'(r));
        rateNow = r;
        settle();
        foreach (predCodes[i]) rd(predCodes[i], pred(predCodes[i]));
    endtask : predict

    ////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial begin
        {nrst, learnDone, learnClamped, cycleTallyIncr, voltCorrection} = 5'h00;
        {num_errors, num_checks, rateNow} = '0;
        seed                = 32'h0000c0ba;
        mode_word           = 16'h0000;
        cellTempDk          = 16'h0b9a;
        packVoltMv          = 16'h2ee0;
        instCurrentMa       = 16'sh0078;
        remainMah           = 16'h03e8;
        remainCwh           = 16'h0123;
        learnedFullMah      = 16'h0bb8;
        learnedFullCwh      = 16'h0bb8;
        nominal_full_amount = 16'h0320;
        repeat (16) @(negedge clk_sys);
        nrst = 1'b1;
        rd(`CMD_ERROR_MARGIN, `MARGIN_RESET);
        rd(`CMD_TIME_TO_FULL, `TIME_INVALID);
        rd(`CMD_CAN_SUPPLY, 16'h0001);
        predict(500);
        rd(`CMD_AVG_CURRENT, 16'h0078);
        remainMah = 16'h07d0;
        repeat (RC) @(negedge clk_sys);
        settle();
        rd(`CMD_TIME_TO_FULL, pred(8'h05));
        predict(-400);
        predict(0);
        remainMah = 16'h0001;
        predict(-32768);
        foreach (evs[i]) begin
            ev(evs[i]);
            rd(`CMD_ERROR_MARGIN, margins[i]);
        end
        packVoltMv = 16'h4e21;
        rd(`CMD_VOLTAGE, `VOLT_MAX_MV);
        repeat (40) begin
            {cellTempDk, packVoltMv, instCurrentMa} = {rnd(), rnd(), rnd()};
            {remainMah, remainCwh, mode_word} = {rnd(), rnd(), rnd()};
            c = codes[rnd() % 5];
            rd(c, direct(c));
            chk("miss flag", {15'h0, c == 8'h30}, {15'h0, m});
        end
        // Window flushed with one steady discharge value
        instCurrentMa = 16'shff38;
        repeat ((`AVG_WINDOW_S + 1) * RC) @(negedge clk_sys);
        settle();
        rd(`CMD_AVG_CURRENT, 16'hff38);
        // Reset lands in the middle of an engine run
        u_host.write_rate(16'shfe70);
        repeat (20) @(negedge clk_sys);
        nrst = 1'b0;
        repeat (3) @(negedge clk_sys);
        nrst = 1'b1;
        rd(`CMD_ERROR_MARGIN, `MARGIN_RESET);
        rd(`CMD_TIME_TO_EMPTY, `TIME_INVALID);
        end_sim();
    end
endmodule : tb
